// ===== led_driver_mode_and_fault_flags.sv
// mode control, fault/event flags and host interrupt of the charge-pump led driver
//
// Notes on behaviour
// - irq release bit set: clearing with events pending drops irq 50 us, then reasserts.
// - irq release bit clear: irq stays asserted when clearing leaves events pending.
// - active-mode bit high runs the device; low is standby, serial port only.
// - dim timeout sets the dim bit; software may also set it.
// - dim operation only while backlight enable is also set.
// - gain-down inhibit: pump raises gain freely, lowers only once all leds off.
// - inhibit clear: pump gain steps up and down with the load.
// - sync sink bit switches all independent sinks on or off together.
// - sync sink bit ignored while any single sink enable bit is set.
// - auto ambient bit: level follows the enabled comparators, overriding the brightness field; with neither comparator enabled the field sets the level.
// - auto ambient clear: comparators ignored, brightness field sets the level.
// - backlight on only with enable bit and active mode both set.
// - output short or overload sets the short flag.
// - overtemperature detector sets the overtemp flag.
// - overvoltage detector sets the overvoltage flag.
// - second light comparator change sets its flag.
// - main light comparator change sets its flag.
// - a flag clears only when the host writes 1 to it.
// - writing 0 or reading a flag leaves it unchanged.
// - a flag drives the irq only when its enable is set; it sets anyway.
`timescale 1ns/1ps
`default_nettype none
`include "led_mode_regs.svh"

module led_driver_mode_and_fault_flags
#(
	parameter int unsigned RELEASE_CYCLES = (`IRQ_RELEASE_TIME_US * 1000) / `CLOCK_PERIOD_NS
)
(
	input  wire logic       clock,                   // 100 mhz system clock
	input  wire logic       rst_b,                   // async reset, active low
	input  wire logic [7:0] reg_addr,                // register index from serial engine
	input  wire logic       reg_wr,                  // one-cycle write strobe
	input  wire logic       reg_rd,                  // one-cycle read strobe
	input  wire logic [7:0] reg_wdata,               // write data
	output logic      [7:0] reg_rdata,               // read data, valid cycle after reg_rd
	input  wire logic       output_short_detect,     // analog short/overload detector pin
	input  wire logic       overtemp_detect,         // analog overtemperature detector pin
	input  wire logic       overvolt_detect,         // analog overvoltage detector pin
	input  wire logic       main_light_cmp_out,      // main ambient comparator pin
	input  wire logic       second_light_cmp_out,    // second ambient comparator pin
	input  wire logic       dim_timeout,             // one-cycle pulse, dim timer expired
	input  wire logic [6:0] single_sink_on,          // single sink enables of sink register
	input  wire logic       office_level_cmp_out,    // office level comparator result
	input  wire logic       dark_level_cmp_out,      // dark level comparator result
	input  wire logic       office_level_cmp_on,     // office comparator enabled
	input  wire logic       dark_level_cmp_on,       // dark comparator enabled
	input  wire logic [1:0] brightness_level_field,  // software level from config register
	input  wire logic       pump_need_up,            // load needs more headroom
	input  wire logic       pump_need_down,          // load would run at a lower gain
	input  wire logic       leds_all_off,            // every led output is off
	output logic            irq_n,                   // host interrupt, active low
	output logic            device_active,           // analog core running
	output logic            backlight_active,        // backlight driven
	output logic            backlight_dim,           // backlight at dim current
	output logic            sync_sinks_on,           // independent sink group on
	output logic      [1:0] backlight_level,         // level in use
	output logic      [2:0] pump_gain                // one-hot 1x / 1.5x / 2x
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	led_mode_pkg::block_state_type state_reg;
	led_mode_pkg::block_state_type state_next;

	logic [`FL_WIDTH-1:0] flag_events;
	logic [`FL_WIDTH-1:0] flag_clear;
	logic [`FL_WIDTH-1:0] flags_after;
	logic                 pending_now;
	logic                 pending_after;
	logic                 clear_attempt;
	logic                 wr_mode;
	logic                 wr_flags;
	logic                 wr_en;
	logic                 auto_level_live;

	// ----------------------------------------
	// combinational decode
	// ----------------------------------------
	always_comb
	begin
		wr_mode  = reg_wr && (reg_addr == `MODE_CONTROL_ADDR);
		wr_flags = reg_wr && (reg_addr == `FAULT_EVENT_FLAGS_ADDR);
		wr_en    = reg_wr && (reg_addr == `FLAG_IRQ_ENABLE_ADDR);

		// ----------------------------------------
		// flag events from the synchronised pins
		// ----------------------------------------
		// only the second sync stage and its delayed copy feed edge detection
		flag_events = '0;
		flag_events[`FL_OUTPUT_SHORT]     = state_reg.pin_sync2[4];
		flag_events[`FL_OVERTEMP]         = state_reg.pin_sync2[3];
		flag_events[`FL_OUTPUT_OVERVOLT]  = state_reg.pin_sync2[2];
		flag_events[`FL_SECOND_LIGHT_CMP] = state_reg.cmp_primed[2] &&
			(state_reg.pin_sync2[1] != state_reg.cmp_prev[1]);
		flag_events[`FL_MAIN_LIGHT_CMP]   = state_reg.cmp_primed[2] &&
			(state_reg.pin_sync2[0] != state_reg.cmp_prev[0]);

		flag_clear  = wr_flags ? reg_wdata[`FL_WIDTH-1:0] : '0;
		// a new event in the clearing cycle wins over the clear
		flags_after = (state_reg.flags & ~flag_clear) | flag_events;

		pending_now   = |(state_reg.flags & state_reg.irq_en);
		pending_after = |(flags_after & state_reg.irq_en);
		clear_attempt = |(flag_clear & state_reg.flags & state_reg.irq_en);

		// ----------------------------------------
		// backlight level source
		// ----------------------------------------
		auto_level_live = state_reg.mode[`MC_AMBIENT_AUTO_LEVEL_ON] &&
			(office_level_cmp_on || dark_level_cmp_on);
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		state_next = state_reg;

		// ----------------------------------------
		// input synchronisers
		// ----------------------------------------
		state_next.pin_sync1  = {output_short_detect, overtemp_detect, overvolt_detect,
			second_light_cmp_out, main_light_cmp_out};
		state_next.pin_sync2  = state_reg.pin_sync1;
		state_next.cmp_prev   = state_reg.pin_sync2[1:0];
		// edges count only once sync2 and its copy both hold real pin samples,
		// so a comparator already high at reset raises no false flag
		state_next.cmp_primed = {state_reg.cmp_primed[1:0], 1'b1};

		// ----------------------------------------
		// writable registers
		// ----------------------------------------
		// mode register; dim timeout set wins over a software write of zero
		if (wr_mode)
		begin
			state_next.mode = reg_wdata[`MC_WIDTH-1:0];
		end
		if (dim_timeout)
		begin
			state_next.mode[`MC_DIM_MODE] = 1'b1;
		end

		state_next.flags = flags_after;
		if (wr_en)
		begin
			state_next.irq_en = reg_wdata[`FL_WIDTH-1:0];
		end

		// ----------------------------------------
		// read path
		// ----------------------------------------
		if (reg_rd)
		begin
			case (reg_addr)
				`MODE_CONTROL_ADDR:      state_next.rdata = {1'b0, state_reg.mode};
				`FAULT_EVENT_FLAGS_ADDR: state_next.rdata = {3'h0, state_reg.flags};
				`FLAG_IRQ_ENABLE_ADDR:   state_next.rdata = {3'h0, state_reg.irq_en};
				default:                 state_next.rdata = 8'h00;
			endcase
		end

		// ----------------------------------------
		// interrupt sequencer
		// ----------------------------------------
		case (state_reg.irq_state)
			led_mode_pkg::IRQ_IDLE:
			begin
				if (pending_after)
				begin
					state_next.irq_state = led_mode_pkg::IRQ_LIVE;
				end
			end
			led_mode_pkg::IRQ_LIVE:
			begin
				if (!pending_after)
				begin
					state_next.irq_state = led_mode_pkg::IRQ_IDLE;
				end
				else if (clear_attempt && state_reg.mode[`MC_IRQ_RELEASE_CFG])
				begin
					state_next.irq_state   = led_mode_pkg::IRQ_GAP;
					state_next.release_cnt = `RELEASE_CNT_WIDTH'(RELEASE_CYCLES - 1);
				end
				// with the release bit clear the line simply stays low
			end
			// clears landing in the gap neither shorten nor restart it
			led_mode_pkg::IRQ_GAP:
			begin
				if (state_reg.release_cnt == '0)
				begin
					state_next.irq_state = pending_after ? led_mode_pkg::IRQ_LIVE
						: led_mode_pkg::IRQ_IDLE;
				end
				else
				begin
					state_next.release_cnt = state_reg.release_cnt - 1'b1;
				end
			end
			default:
			begin
				state_next.irq_state = led_mode_pkg::IRQ_IDLE;
			end
		endcase

		// ----------------------------------------
		// charge pump gain
		// ----------------------------------------
		// charge pump gain; held at 1x in standby
		if (!state_reg.mode[`MC_ACTIVE_MODE_N_STANDBY])
		begin
			state_next.gain = led_mode_pkg::GAIN_1X;
		end
		else
		begin
			case (state_reg.gain)
				led_mode_pkg::GAIN_1X:
				begin
					if (pump_need_up)
					begin
						state_next.gain = led_mode_pkg::GAIN_1P5X;
					end
				end
				led_mode_pkg::GAIN_1P5X:
				begin
					if (pump_need_up)
					begin
						state_next.gain = led_mode_pkg::GAIN_2X;
					end
					else if (state_reg.mode[`MC_PUMP_GAIN_DOWN_INHIB])
					begin
						if (leds_all_off)
						begin
							state_next.gain = led_mode_pkg::GAIN_1X;
						end
					end
					else if (pump_need_down)
					begin
						state_next.gain = led_mode_pkg::GAIN_1X;
					end
				end
				led_mode_pkg::GAIN_2X:
				begin
					if (state_reg.mode[`MC_PUMP_GAIN_DOWN_INHIB])
					begin
						if (leds_all_off)
						begin
							state_next.gain = led_mode_pkg::GAIN_1X;
						end
					end
					else if (pump_need_down)
					begin
						state_next.gain = led_mode_pkg::GAIN_1P5X;
					end
				end
				default:
				begin
					state_next.gain = led_mode_pkg::GAIN_1X;
				end
			endcase
		end

		// ----------------------------------------
		// backlight level
		// ----------------------------------------
		// registered, so the level lags a comparator change by one clock
		if (auto_level_live)
		begin
			if (dark_level_cmp_on && dark_level_cmp_out)
			begin
				state_next.level = `LEVEL_DARK;
			end
			else if (office_level_cmp_on && office_level_cmp_out)
			begin
				state_next.level = `LEVEL_OFFICE;
			end
			else
			begin
				state_next.level = `LEVEL_DAYLIGHT;
			end
		end
		else
		begin
			state_next.level = brightness_level_field;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg.pin_sync1   <= '0;
			state_reg.pin_sync2   <= '0;
			state_reg.cmp_prev    <= '0;
			state_reg.cmp_primed  <= '0;
			state_reg.level       <= `LEVEL_DAYLIGHT;
			state_reg.mode        <= `MODE_CONTROL_RESET;
			state_reg.flags       <= `FAULT_EVENT_FLAGS_RESET;
			state_reg.irq_en      <= `FLAG_IRQ_ENABLE_RESET;
			state_reg.rdata       <= 8'h00;
			state_reg.irq_state   <= led_mode_pkg::IRQ_IDLE;
			state_reg.release_cnt <= '0;
			state_reg.gain        <= led_mode_pkg::GAIN_1X;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_comb
	begin
		reg_rdata = state_reg.rdata;
		// ----------------------------------------
		// interrupt line and mode outputs
		// ----------------------------------------
		// release gap masks the line even while events stay pending
		irq_n = !(pending_now && (state_reg.irq_state == led_mode_pkg::IRQ_LIVE));
		device_active    = state_reg.mode[`MC_ACTIVE_MODE_N_STANDBY];
		backlight_active = state_reg.mode[`MC_BACKLIGHT_ON] &&
			state_reg.mode[`MC_ACTIVE_MODE_N_STANDBY];
		backlight_dim    = backlight_active && state_reg.mode[`MC_DIM_MODE];
		// any single sink enable takes the group bit out of play
		sync_sinks_on    = device_active && (single_sink_on == 7'h00) &&
			state_reg.mode[`MC_SYNC_SINK_GROUP_ON];
		backlight_level  = state_reg.level;
		pump_gain = state_reg.gain;
	end

endmodule
`default_nettype wire

// ===== led_mode_regs.svh
// offsets, field positions, reset values and timing counts of the mode and flag registers
`ifndef LED_MODE_REGS_SVH
`define LED_MODE_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MODE_CONTROL_ADDR        8'h01
`define FAULT_EVENT_FLAGS_ADDR   8'h02
`define FLAG_IRQ_ENABLE_ADDR     8'h03

// ----------------------------------------
// mode_control fields
// ----------------------------------------
`define MC_IRQ_RELEASE_CFG       6
`define MC_ACTIVE_MODE_N_STANDBY 5
`define MC_DIM_MODE              4
`define MC_PUMP_GAIN_DOWN_INHIB  3
`define MC_SYNC_SINK_GROUP_ON    2
`define MC_AMBIENT_AUTO_LEVEL_ON 1
`define MC_BACKLIGHT_ON          0
`define MC_WIDTH                 7

// ----------------------------------------
// fault_event_flags / enable fields
// ----------------------------------------
`define FL_OUTPUT_SHORT          4
`define FL_OVERTEMP              3
`define FL_OUTPUT_OVERVOLT       2
`define FL_SECOND_LIGHT_CMP      1
`define FL_MAIN_LIGHT_CMP        0
`define FL_WIDTH                 5

// ----------------------------------------
// reset values
// ----------------------------------------
`define MODE_CONTROL_RESET       7'h00
`define FAULT_EVENT_FLAGS_RESET  5'h00
`define FLAG_IRQ_ENABLE_RESET    5'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define CLOCK_PERIOD_NS          10
`define IRQ_RELEASE_TIME_US      50
`define RELEASE_CNT_WIDTH        13

// ----------------------------------------
// brightness levels
// ----------------------------------------
`define LEVEL_DAYLIGHT           2'h0
`define LEVEL_OFFICE             2'h1
`define LEVEL_DARK               2'h2

`endif

// ===== led_mode_pkg.sv
// types for the mode control and fault flag block
`include "led_mode_regs.svh"

package led_mode_pkg;

	typedef enum logic [2:0]
	{
		IRQ_IDLE = 3'h1,
		IRQ_LIVE = 3'h2,
		IRQ_GAP  = 3'h4
	} irq_state_type;

	typedef enum logic [2:0]
	{
		GAIN_1X   = 3'h1,
		GAIN_1P5X = 3'h2,
		GAIN_2X   = 3'h4
	} pump_gain_type;

	typedef struct packed
	{
		logic [4:0]                     pin_sync1;
		logic [4:0]                     pin_sync2;
		logic [1:0]                     cmp_prev;
		logic [2:0]                     cmp_primed;
		logic [`MC_WIDTH-1:0]           mode;
		logic [`FL_WIDTH-1:0]           flags;
		logic [`FL_WIDTH-1:0]           irq_en;
		logic [7:0]                     rdata;
		irq_state_type                  irq_state;
		logic [`RELEASE_CNT_WIDTH-1:0]  release_cnt;
		pump_gain_type                  gain;
		logic [1:0]                     level;
	} block_state_type;

endpackage

// ===== led_mode_monitor.sv
// assertion checker for the mode control and fault flag block
`timescale 1ns/1ps
`default_nettype none
module led_mode_monitor
#(
	parameter int RELEASE_CYCLES = 8
)
(
	input wire logic       clock,            // system clock
	input wire logic       rst_b,            // async reset, active low
	input wire logic [7:0] reg_addr,         // register index
	input wire logic       reg_wr,           // write strobe
	input wire logic       reg_rd,           // read strobe
	input wire logic [7:0] reg_wdata,        // write data
	input wire logic [7:0] reg_rdata,        // read data
	input wire logic       overtemp_detect,  // overtemperature pin
	input wire logic       dim_timeout,      // dim timer pulse
	input wire logic [6:0] single_sink_on,   // single sink enables
	input wire logic       irq_n,            // host interrupt, active low
	input wire logic       device_active,    // analog core running
	input wire logic       backlight_active, // backlight driven
	input wire logic       backlight_dim,    // dim current
	input wire logic       sync_sinks_on     // sink group on
);
	// release-pulse bit has no port of its own, so mirror it from writes
	logic irq_cfg_reg;

	// last cycle still released, capped so the delay stays short for the tools
	localparam int GAP_LAST = (RELEASE_CYCLES > 300) ? 299 : RELEASE_CYCLES - 1;

	always_ff @(posedge clock or negedge rst_b)
		if (!rst_b)
			irq_cfg_reg <= 1'b0;
		else if (reg_wr && reg_addr == 8'h01)
			irq_cfg_reg <= reg_wdata[6];

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence mode_write;
		reg_wr && reg_addr == 8'h01;
	endsequence

	sequence clear_while_live;
		irq_cfg_reg && !irq_n && reg_wr && reg_addr == 8'h02 && reg_wdata != 8'h00;
	endsequence

	chk_mode_standby:
		assert property (mode_write |=> device_active == $past(reg_wdata[5]))
		else $error("device_active does not follow the mode write");
	chk_backlight_gate:
		assert property (mode_write |=> backlight_active == ($past(reg_wdata[5]) && $past(reg_wdata[0])))
		else $error("backlight_active wrong after mode write");
	chk_dim_needs_bl:
		assert property (mode_write |=> backlight_dim ==
			($past(reg_wdata[5]) && $past(reg_wdata[0]) && ($past(reg_wdata[4]) || $past(dim_timeout))))
		else $error("dim state wrong after mode write");
	chk_sink_blocked:
		assert property (single_sink_on != 7'h00 |-> !sync_sinks_on)
		else $error("sink group on while a single sink is enabled");
	chk_sink_group:
		assert property (mode_write ##1 single_sink_on == 7'h00 |-> sync_sinks_on == ($past(reg_wdata[2]) && device_active))
		else $error("sink group does not follow mode write");
	chk_flag_reserved:
		assert property (reg_rd && reg_addr == 8'h02 |=> reg_rdata[7:5] == 3'h0)
		else $error("reserved flag bits not zero");
	chk_zero_write_keeps:
		assert property (!irq_n && reg_wr && reg_addr == 8'h02 && reg_wdata == 8'h00 |=> !irq_n)
		else $error("writing zero released the interrupt");
	chk_overtemp_sets:
		assert property (overtemp_detect [*5] ##0 (reg_rd && reg_addr == 8'h02) |=> reg_rdata[3])
		else $error("overtemperature flag not set");
	chk_release_gap:
		assert property (clear_while_live ##1 irq_n |-> ##GAP_LAST irq_n)
		else $error("interrupt release gap too short");
endmodule

bind led_driver_mode_and_fault_flags led_mode_monitor #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_mon
(
	.clock, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .overtemp_detect,
	.dim_timeout, .single_sink_on, .irq_n, .device_active, .backlight_active, .backlight_dim,
	.sync_sinks_on
);
`default_nettype wire

// ===== led_host_model.sv
// host side of the register port: one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
module led_host_model
(
	input  wire logic       clock,     // system clock
	output var  logic [7:0] reg_addr,  // register index
	output var  logic       reg_wr,    // write strobe
	output var  logic       reg_rd,    // read strobe
	output var  logic [7:0] reg_wdata, // write data
	input  wire logic [7:0] reg_rdata  // read data
);
	initial
	begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end

	// idle lines show the inverse so a stale index or datum cannot pass unseen
	task automatic put(input logic [7:0] a, input logic [7:0] v, input logic w);
		@(posedge clock);
		#1;
		reg_addr = a;
		reg_wdata = v;
		reg_wr = w;
		reg_rd = !w;
		@(posedge clock);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~v;
	endtask

	// a flag is cleared by writing 1 to its position
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		put(a, v, 1'b1);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		put(a, 8'h00, 1'b0);
		v = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ===== test_led_driver_mode_and_fault_flags.sv
// self-checking bench for the mode control and fault flag block
`timescale 1ns/1ps
`default_nettype none
module test_led_driver_mode_and_fault_flags;
	localparam int RC = 8;
	logic       clock, rst_b, reg_wr, reg_rd, irq_n, dim_timeout, up, dn, alloff;
	logic       device_active, backlight_active, backlight_dim, sync_sinks_on;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, q, d;
	logic [7:0] adr [4] = '{8'h01, 8'h02, 8'h03, 8'h7f};
	logic [6:0] sinks;
	logic [4:0] pin;
	logic [1:0] lvl_out, lvl_on, field, level;
	logic [2:0] gain;
	int         seed = 32'h44a7;
	int         n_mismatch, samples_checked, i, k;

	led_driver_mode_and_fault_flags #(.RELEASE_CYCLES(RC)) u_dut
	(
		.clock, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.output_short_detect(pin[4]), .overtemp_detect(pin[3]), .overvolt_detect(pin[2]),
		.second_light_cmp_out(pin[1]), .main_light_cmp_out(pin[0]), .dim_timeout,
		.single_sink_on(sinks), .office_level_cmp_out(lvl_out[0]),
		.dark_level_cmp_out(lvl_out[1]), .office_level_cmp_on(lvl_on[0]),
		.dark_level_cmp_on(lvl_on[1]), .brightness_level_field(field), .pump_need_up(up),
		.pump_need_down(dn), .leds_all_off(alloff), .irq_n, .device_active,
		.backlight_active, .backlight_dim, .sync_sinks_on, .backlight_level(level),
		.pump_gain(gain)
	);
	led_host_model u_host
	(
		.clock, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata
	);

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// dark outranks office; auto needs at least one comparator switched on
	function automatic logic [1:0] lvl_exp(input logic auto_on);
		if (!auto_on || lvl_on == 2'h0)
			return field;
		if (lvl_on[1] && lvl_out[1])
			return 2'h2;
		return {1'b0, lvl_on[0] & lvl_out[0]};
	endfunction

	initial
	begin
		#100000;
		n_mismatch++;
		conclude();
	end

	initial
	begin
		{rst_b, pin, dim_timeout, sinks, lvl_out, lvl_on, field, up, dn, alloff} = '0;
		tick(4);
		rst_b = 1'b1;
		check(irq_n, 1'b1);
		foreach (adr[j])
		begin
			u_host.rd(adr[j], q);
			check(q, 8'h00);
		end
		$display("reset test done");
		for (i = 0; i < 12; i++)
		begin
			d = 8'($random(seed));
			sinks = (i % 2 == 1) ? 7'($random(seed)) : 7'h00;
			{lvl_out, lvl_on} = 4'($random(seed));
			field = 2'(i % 3);
			u_host.wr(8'h01, d);
			u_host.rd(8'h01, q);
			check(q, d & 8'h7f);
			check(device_active, d[5]);
			check(backlight_active, d[5] & d[0]);
			check(backlight_dim, d[5] & d[0] & d[4]);
			check(sync_sinks_on, d[5] & d[2] & (sinks == 7'h00));
			check(level, lvl_exp(d[1]));
		end
		$display("mode test done");
		u_host.wr(8'h01, 8'h21);
		dim_timeout = 1'b1;
		tick(1);
		dim_timeout = 1'b0;
		u_host.rd(8'h01, q);
		check(q, 8'h31);
		check(backlight_dim, 1'b1);
		$display("dim test done");
		// enables off: every flag must still latch without touching the interrupt
		u_host.wr(8'h03, 8'h00);
		for (k = 0; k < 5; k++)
		begin
			pin[k] = ~pin[k];
			tick(8);
			u_host.rd(8'h02, q);
			check(q[k], 1'b1);
			check(irq_n, 1'b1);
			pin[k] = (k > 1) ? 1'b0 : pin[k];
			u_host.wr(8'h02, 8'h00);
			u_host.rd(8'h02, q);
			check(q[k], 1'b1);
			u_host.wr(8'h02, 8'h01 << k);
			u_host.rd(8'h02, q);
			check(q, 8'h00);
		end
		$display("flag test done");
		u_host.wr(8'h03, 8'h03);
		u_host.wr(8'h01, 8'h60);
		pin[1:0] = ~pin[1:0];
		tick(6);
		check(irq_n, 1'b0);
		u_host.wr(8'h02, 8'h01);
		for (i = 0; i < 30 && irq_n === 1'b1; i++)
			tick(1);
		check(8'(i), 8'(RC));
		u_host.wr(8'h01, 8'h20);
		pin[0] = ~pin[0];
		tick(6);
		u_host.wr(8'h02, 8'h00);
		u_host.wr(8'h02, 8'h01);
		check(irq_n, 1'b0);
		tick(3);
		check(irq_n, 1'b0);
		u_host.wr(8'h02, 8'h03);
		check(irq_n, 1'b1);
		$display("irq test done");
		u_host.wr(8'h01, 8'h28);
		up = 1'b1;
		tick(4);
		up = 1'b0;
		dn = 1'b1;
		tick(4);
		check(gain, 3'h4);
		alloff = 1'b1;
		tick(4);
		check(gain, 3'h1);
		alloff = 1'b0;
		up = 1'b1;
		tick(4);
		up = 1'b0;
		u_host.wr(8'h01, 8'h20);
		tick(4);
		check(gain, 3'h1);
		$display("gain test done");
		conclude();
	end
endmodule
`default_nettype wire
